// ===== core/itc_core.sv
`timescale 1ns/1ps
module itc_core (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [itc_pkg::NUM_HW-1:0] hw_event_in,
	input wire logic trap_pin_in,
	input wire logic interruptible_in,
	input wire logic [19:0] pc_in,
	input wire logic irq_global_on_instr_in,
	input wire logic irq_global_off_instr_in,
	input wire logic irq_return_in,
	input wire logic trap_return_in,
	input wire logic sw_call_in,
	input wire logic [5:0] sw_index_in,
	input wire logic [19:0] vbase_in,
	input wire logic vbase_we_in,
	input wire logic prio_a_we_in,
	input wire logic prio_b_we_in,
	input wire logic [19:0] prio_wdata_in,
	input wire logic status_we_in,
	input wire logic [19:0] status_wdata_in,
	input wire logic [3:0] pin_mux_select_field_in,
	input wire logic [3:0] general_io_bit_in,
	output logic [19:0] int_priority_ctrl_a_out,
	output logic [19:0] int_priority_ctrl_b_out,
	output logic [19:0] status_out,
	output logic [19:0] vbase_out,
	output logic irq_global_en_out,
	output logic redirect_out,
	output logic [19:0] redirect_addr_out,
	output logic [19:0] irq_return_reg_out,
	output logic [19:0] trap_return_reg_out,
	output logic in_trap_out,
	output logic [1:0] run_level_out,
	output logic service_ack_pin_out,
	output logic [3:0] service_code_pins_out
);
	localparam int N = itc_pkg::NUM_HW;
	localparam int FL = itc_pkg::FIELD_LSB;

	logic trap_sync;
	logic trap_prev_ff;
	logic [2*N-1:0] prio_ff;
	logic [N-1:0] pend_ff;
	logic [19:0] vbase_ff;
	logic gie_ff;
	logic in_trap_ff;
	logic [1:0] level_ff;
	logic [1:0] saved_level_ff;
	logic [3:0] code_ff;
	logic [3:0] saved_code_ff;
	logic [19:0] pi_ff;
	logic [19:0] ptrap_ff;
	logic redirect_ff;
	logic [19:0] addr_ff;
	logic [3:0] pins_ff;
	logic [19:0] prio_a_ff;
	logic [19:0] prio_b_ff;
	logic ack_start;
	logic ack_q;
	itc_pkg::itc_state_type state_ff;
	itc_pkg::itc_state_type nxt_state;

	logic trap_req;
	logic take_trap;
	logic take_sw;
	logic take_hw;
	logic hw_found;
	logic [3:0] hw_sel;
	logic [1:0] hw_lvl;
	logic [N-1:0] pend_clr;

	////////////////////////////////////////////////////////////////
	itc_sync u_trap_sync (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.async_in(trap_pin_in),
		.sync_out(trap_sync)
	);

	itc_ack_timer #(.CYCLES(itc_pkg::ACK_CYCLES)) u_ack (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.start_in(ack_start),
		.ack_out(ack_q)
	);

	////////////////////////////////////////////////////////////////
	// trap edge on pin
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			trap_prev_ff <= 1'b0;
		end else begin
			trap_prev_ff <= trap_sync;
		end
	end
	assign trap_req = trap_sync && !trap_prev_ff;

	always_comb begin
		logic [1:0] lv;
		lv = 2'h0;
		hw_found = 1'b0;
		hw_sel = 4'h0;
		hw_lvl = itc_pkg::NO_LEVEL;
		for (int i = N - 1; i >= 0; i--) begin
			lv = prio_ff[2*i +: 2];
			if (pend_ff[i] && lv != itc_pkg::PRIO_OFF && lv >= hw_lvl) begin
				hw_found = 1'b1;
				hw_sel = 4'(i);
				hw_lvl = lv;
			end
		end
	end

	assign take_trap = trap_req && !in_trap_ff && interruptible_in;
	assign take_sw = sw_call_in && !take_trap && !in_trap_ff;
	assign take_hw = hw_found && gie_ff && interruptible_in && !in_trap_ff
		&& !take_trap && !take_sw && (hw_lvl > level_ff);
	assign ack_start = take_trap || take_sw || take_hw;

	////////////////////////////////////////////////////////////////
	// priority fields
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			prio_ff <= itc_pkg::PRIO_RESET;
		end else begin
			if (prio_a_we_in) begin
				prio_ff[17:0] <= prio_wdata_in[19:FL];
			end
			if (prio_b_we_in) begin
				prio_ff[29:18] <= prio_wdata_in[17:6];
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			prio_a_ff <= 20'h00000;
			prio_b_ff <= 20'h00000;
		end else begin
			prio_a_ff <= {prio_ff[17:0], 2'h0};
			prio_b_ff <= {2'h0, prio_ff[29:18], 6'h00};
		end
	end

	assign pend_clr = status_we_in ?
		status_wdata_in[N+itc_pkg::STATUS_LSB-1:itc_pkg::STATUS_LSB] :
		{N{1'b0}};

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			pend_ff <= {N{1'b0}};
		end else begin
			for (int i = 0; i < N; i++) begin
				if (hw_event_in[i]) begin
					pend_ff[i] <= 1'b1;
				end else if (pend_clr[i] || (take_hw && hw_sel == 4'(i))) begin
					pend_ff[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			vbase_ff <= 20'h00000;
		end else if (vbase_we_in) begin
			vbase_ff <= vbase_in;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			gie_ff <= 1'b0;
		end else if (take_hw || take_sw || irq_global_off_instr_in) begin
			gie_ff <= 1'b0;
		end else if (irq_global_on_instr_in || irq_return_in) begin
			gie_ff <= 1'b1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			in_trap_ff <= 1'b0;
		end else if (take_trap) begin
			in_trap_ff <= 1'b1;
		end else if (trap_return_in) begin
			in_trap_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			level_ff <= 2'h0;
			saved_level_ff <= 2'h0;
		end else if (take_hw) begin
			saved_level_ff <= level_ff;
			level_ff <= hw_lvl;
		end else if (irq_return_in && !in_trap_ff) begin
			level_ff <= saved_level_ff;
			saved_level_ff <= 2'h0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			ptrap_ff <= 20'h00000;
		end else if (take_trap) begin
			ptrap_ff <= pc_in;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			pi_ff <= 20'h00000;
		end else if (take_sw || take_hw) begin
			pi_ff <= pc_in;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			redirect_ff <= 1'b0;
			addr_ff <= 20'h00000;
		end else begin
			redirect_ff <= ack_start;
			if (take_trap) begin
				addr_ff <= vbase_ff + itc_pkg::TRAP_OFFSET;
			end else if (take_sw) begin
				addr_ff <= itc_pkg::itc_vector(vbase_ff, itc_pkg::SW_OFFSET0,
					{1'b0, sw_index_in});
			end else if (take_hw) begin
				addr_ff <= itc_pkg::itc_vector(vbase_ff, itc_pkg::HW_OFFSET0,
					{3'h0, hw_sel});
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			code_ff <= itc_pkg::CODE_IDLE;
			saved_code_ff <= itc_pkg::CODE_IDLE;
		end else if (take_trap) begin
			saved_code_ff <= code_ff;
			code_ff <= itc_pkg::CODE_TRAP;
		end else if (take_sw) begin
			code_ff <= itc_pkg::CODE_SW;
		end else if (take_hw) begin
			code_ff <= itc_pkg::CODE_HW0 + hw_sel;
		end else if (trap_return_in && in_trap_ff) begin
			code_ff <= saved_code_ff;
		end else if (irq_return_in && !in_trap_ff) begin
			code_ff <= itc_pkg::CODE_IDLE;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			itc_pkg::ITC_IDLE: if (ack_start) nxt_state = itc_pkg::ITC_ACK;
			itc_pkg::ITC_ACK: if (!ack_q) nxt_state = itc_pkg::ITC_RUN;
			itc_pkg::ITC_RUN: begin
				if (ack_start) begin
					nxt_state = itc_pkg::ITC_ACK;
				end else if (code_ff == itc_pkg::CODE_IDLE) begin
					nxt_state = itc_pkg::ITC_IDLE;
				end
			end
			default: nxt_state = itc_pkg::ITC_IDLE;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			state_ff <= itc_pkg::ITC_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			pins_ff <= 4'hF;
		end else if (pin_mux_select_field_in == 4'h0) begin
			pins_ff <= code_ff;
		end else begin
			pins_ff <= general_io_bit_in;
		end
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			status_out <= 20'h00000;
			vbase_out <= 20'h00000;
			irq_global_en_out <= 1'b0;
			in_trap_out <= 1'b0;
			run_level_out <= 2'h0;
			service_ack_pin_out <= 1'b0;
		end else begin
			status_out <= {4'h0, pend_ff, 1'b0};
			vbase_out <= vbase_ff;
			irq_global_en_out <= gie_ff;
			in_trap_out <= in_trap_ff;
			run_level_out <= level_ff;
			service_ack_pin_out <= ack_q;
		end
	end

	assign int_priority_ctrl_a_out = prio_a_ff;
	assign int_priority_ctrl_b_out = prio_b_ff;
	assign redirect_out = redirect_ff;
	assign redirect_addr_out = addr_ff;
	assign irq_return_reg_out = pi_ff;
	assign trap_return_reg_out = ptrap_ff;
	assign service_code_pins_out = pins_ff;
endmodule // itc_core

// ===== core/itc_pkg.sv
package itc_pkg;
	// Sources, table geometry and service codes
	localparam int NUM_HW = 15;
	localparam int NUM_SW = 64;
	localparam int VBASE_W = 20;
	localparam int TABLE_WORDS = 352;
	localparam int SLOT_WORDS = 4;
	localparam logic [VBASE_W-1:0] TRAP_OFFSET = 20'h00004;
	localparam logic [VBASE_W-1:0] HW_OFFSET0 = 20'h00014;
	localparam logic [VBASE_W-1:0] SW_OFFSET0 = 20'h00060;
	localparam logic [3:0] CODE_IDLE = 4'hF;
	localparam logic [3:0] CODE_TRAP = 4'hD;
	localparam logic [3:0] CODE_SW = 4'hC;
	localparam logic [3:0] CODE_HW0 = 4'h1;
	localparam int ACK_CYCLES = 3;
	localparam logic [2*NUM_HW-1:0] PRIO_RESET = 30'h00000000;
	localparam logic [1:0] PRIO_OFF = 2'h0;
	localparam logic [1:0] NO_LEVEL = 2'h0;
	// Bit position of source 0 in the priority and status words
	localparam int FIELD_LSB = 2;
	localparam int STATUS_LSB = 1;

	typedef enum logic [1:0] {
		ITC_IDLE = 2'h0,
		ITC_ACK = 2'h1,
		ITC_RUN = 2'h3
	} itc_state_type;

	// Vector of a slot index, each slot four words
	function automatic logic [VBASE_W-1:0] itc_vector(
		input logic [VBASE_W-1:0] base,
		input logic [VBASE_W-1:0] offset,
		input logic [6:0] index);
		logic [VBASE_W-1:0] idx;
		idx = {{(VBASE_W-7){1'b0}}, index};
		itc_vector = base + offset + (idx << 2);
	endfunction
endpackage

// ===== core/itc_ack_timer.sv
`timescale 1ns/1ps
module itc_ack_timer #(
	parameter int CYCLES = 3
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	output logic ack_out
);
	logic [3:0] count_ff;

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			count_ff <= 4'h0;
		end else if (start_in) begin
			count_ff <= 4'(CYCLES);
		end else if (count_ff != 4'h0) begin
			count_ff <= count_ff - 4'h1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			ack_out <= 1'b0;
		end else begin
			ack_out <= start_in || (count_ff > 4'h1);
		end
	end
endmodule // itc_ack_timer

// ===== core/itc_sync.sv
`timescale 1ns/1ps
module itc_sync (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_ff;

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			meta_ff <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule // itc_sync

// ===== testbench/itc_core_chk.sv
`timescale 1ns/1ps
module itc_core_chk (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [itc_pkg::NUM_HW-1:0] hw_event_in,
	input wire logic interruptible_in,
	input wire logic irq_global_on_instr_in,
	input wire logic irq_global_off_instr_in,
	input wire logic irq_return_in,
	input wire logic trap_return_in,
	input wire logic sw_call_in,
	input wire logic status_we_in,
	input wire logic [19:0] status_wdata_in,
	input wire logic [3:0] pin_mux_select_field_in,
	input wire logic [3:0] general_io_bit_in,
	input wire logic [19:0] status_out,
	input wire logic [19:0] vbase_out,
	input wire logic irq_global_en_out,
	input wire logic redirect_out,
	input wire logic [19:0] redirect_addr_out,
	input wire logic service_ack_pin_out,
	input wire logic [3:0] service_code_pins_out
);
	default clocking dc @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	ack_len_a: assert property ($rose(service_ack_pin_out) |->
		service_ack_pin_out [*3] ##1 !service_ack_pin_out)
		else $error("ack pulse length wrong");
	ack_follow_a: assert property (redirect_out |=> service_ack_pin_out)
		else $error("ack missing after redirect");
	trap_code_a: assert property (redirect_out &&
		pin_mux_select_field_in == 4'h0 &&
		redirect_addr_out == vbase_out + itc_pkg::TRAP_OFFSET
		|=> service_code_pins_out == itc_pkg::CODE_TRAP)
		else $error("trap code wrong");
	mux_io_a: assert property ((pin_mux_select_field_in != 4'h0 &&
		$stable(general_io_bit_in)) [*3]
		|-> service_code_pins_out == general_io_bit_in)
		else $error("muxed pins wrong");
	gie_off_a: assert property (irq_global_off_instr_in &&
		!irq_global_on_instr_in && !irq_return_in
		|-> ##2 !irq_global_en_out)
		else $error("enable not cleared");
	gie_on_a: assert property (irq_global_on_instr_in &&
		!irq_global_off_instr_in && !sw_call_in && !interruptible_in
		|-> ##2 irq_global_en_out)
		else $error("enable not set");
	iret_gie_a: assert property (irq_return_in && !irq_global_en_out &&
		!irq_global_off_instr_in && !sw_call_in
		|=> (redirect_out or ##1 irq_global_en_out))
		else $error("return did not enable");
	treturn_gie_a: assert property (trap_return_in &&
		!irq_global_on_instr_in && !irq_return_in
		|-> ##2 (!irq_global_en_out || $past(irq_global_en_out)))
		else $error("trap return changed enable");
	w1c_clear_a: assert property (status_we_in &&
		hw_event_in == 15'h0000 |-> ##2
		(status_out & $past(status_wdata_in, 2) & 20'h0FFFE) == 20'h00000)
		else $error("pending not cleared");
	pend_set_a: assert property (hw_event_in != 15'h0000 &&
		!interruptible_in |-> ##2
		(status_out[15:1] & $past(hw_event_in, 2)) == $past(hw_event_in, 2))
		else $error("pending not set");
	cover property (redirect_out ##1 service_ack_pin_out);
	cover property (sw_call_in);
	cover property (trap_return_in);
	cover property (irq_return_in ##[1:20] redirect_out);
endmodule // itc_core_chk

// ===== testbench/itc_seq_model.sv
`timescale 1ns/1ps
module itc_seq_model (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic redirect_in,
	input wire logic in_trap_in,
	input wire logic hold_in,
	input wire logic [3:0] len_in,
	output logic interruptible_out,
	output logic [19:0] pc_out,
	output logic irq_return_out,
	output logic trap_return_out
);
	logic [3:0] left_ff;
	always_ff @(posedge clock_in) begin
		if (!rst_n_in)
			pc_out <= 20'h00000;
		else
			pc_out <= pc_out + 20'h00001;
	end
	assign interruptible_out = !hold_in;
	always_ff @(posedge clock_in) begin
		irq_return_out <= 1'b0;
		trap_return_out <= 1'b0;
		if (!rst_n_in)
			left_ff <= 4'h0;
		else if (redirect_in)
			left_ff <= len_in;
		else if (left_ff == 4'h1) begin
			left_ff <= 4'h0;
			irq_return_out <= !in_trap_in;
			trap_return_out <= in_trap_in;
		end else if (left_ff != 4'h0)
			left_ff <= left_ff - 4'h1;
	end
endmodule // itc_seq_model

// ===== testbench/itc_core_tb_top.sv
`timescale 1ns/1ps
module itc_core_tb_top;
	typedef struct {
		logic [19:0] addr;
		logic [3:0] code;
		logic trap;
		logic [1:0] lvl;
	} itc_exp_type;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [14:0] hw_event_in = 15'h0000;
	logic trap_pin_in = 1'b0;
	logic sw_call_in = 1'b0;
	logic [5:0] sw_index_in = 6'h00;
	logic [19:0] vbase_in = 20'h00000;
	logic vbase_we_in = 1'b0;
	logic prio_a_we_in = 1'b0;
	logic prio_b_we_in = 1'b0;
	logic [19:0] prio_wdata_in = 20'h00000;
	logic status_we_in = 1'b0;
	logic [19:0] status_wdata_in = 20'h00000;
	logic [3:0] pin_mux_select_field_in = 4'h0;
	logic [3:0] general_io_bit_in = 4'h0;
	logic irq_global_on_instr_in = 1'b0;
	logic irq_global_off_instr_in = 1'b0;
	logic hold = 1'b0;
	logic [3:0] len = 4'h6;
	logic interruptible_in, irq_return_in, trap_return_in;
	logic [19:0] pc_in, int_priority_ctrl_a_out, int_priority_ctrl_b_out;
	logic [19:0] status_out, vbase_out, redirect_addr_out;
	logic [19:0] irq_return_reg_out, trap_return_reg_out;
	logic irq_global_en_out, redirect_out, in_trap_out;
	logic service_ack_pin_out;
	logic [1:0] run_level_out;
	logic [3:0] service_code_pins_out;
	logic [31:0] r;
	logic [19:0] vb, s0;
	logic [5:0] idx;
	logic code_due = 1'b0;
	itc_exp_type q[$];
	itc_exp_type cur;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;

	always #5 clock_in = ~clock_in;
	itc_core dut_u (.*);
	itc_seq_model model_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.redirect_in(redirect_out), .in_trap_in(in_trap_out),
		.hold_in(hold), .len_in(len), .interruptible_out(interruptible_in),
		.pc_out(pc_in), .irq_return_out(irq_return_in),
		.trap_return_out(trap_return_in));

	task automatic check(input string name, input logic [19:0] seen,
		input logic [19:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clock_in);
	endtask
	task automatic push(input logic [19:0] a, input logic [3:0] c,
		input logic t, input logic [1:0] l);
		q.push_back('{a, c, t, l});
	endtask
	task automatic wait_done();
		repeat (400) if (q.size() != 0) tick(1);
		tick(20);
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(negedge clock_in) begin
		if (code_due) begin
			check("ack", 20'(service_ack_pin_out), 20'h00001);
			check("code", 20'(service_code_pins_out), 20'(cur.code));
			check("level", 20'(run_level_out), 20'(cur.lvl));
			check("in trap", 20'(in_trap_out), 20'(cur.trap));
			code_due = 1'b0;
		end
		if (rst_n_in && redirect_out) begin
			if (q.size() == 0)
				check("unexpected take", 20'h00001, 20'h00000);
			else begin
				cur = q.pop_front();
				check("vector", redirect_addr_out, cur.addr);
				check("saved pc", cur.trap ? trap_return_reg_out :
					irq_return_reg_out, pc_in - 20'h00001);
				code_due = 1'b1;
			end
		end
		cycles++;
		if (cycles > 3000) begin
			failures++;
			finish_test();
		end
	end
	initial begin
		r = $urandom(32'h2336A0F7);
		tick(6);
		check("code", 20'(service_code_pins_out), 20'h0000F);
		check("ack", 20'(service_ack_pin_out), 20'h00000);
		check("prio", int_priority_ctrl_a_out, 20'h00000);
		check("prio b", int_priority_ctrl_b_out, 20'h00000);
		rst_n_in = 1'b1;
		hw_event_in = 15'h0400;
		tick(1);
		hw_event_in = 15'h0000;
		tick(1);
		check("pending", status_out, 20'h00800);
		status_we_in = 1'b1;
		status_wdata_in = 20'h007FE;
		tick(1);
		status_we_in = 1'b0;
		tick(1);
		check("pending", status_out, 20'h00800);
		status_we_in = 1'b1;
		status_wdata_in = 20'h0FFFE;
		r = $urandom;
		vb = r[19:0];
		vbase_in = vb;
		vbase_we_in = 1'b1;
		prio_wdata_in = 20'h12200;
		prio_a_we_in = 1'b1;
		tick(1);
		status_we_in = 1'b0;
		vbase_we_in = 1'b0;
		prio_a_we_in = 1'b0;
		prio_b_we_in = 1'b1;
		prio_wdata_in = 20'h00000;
		tick(1);
		prio_b_we_in = 1'b0;
		tick(2);
		check("cleared", status_out, 20'h00000);
		check("prio", int_priority_ctrl_a_out, 20'h12200);
		check("base", vbase_out, vb);
		hold = 1'b1;
		irq_global_on_instr_in = 1'b1;
		tick(1);
		irq_global_on_instr_in = 1'b0;
		r = $urandom;
		hw_event_in = {r[14:9], 9'h0A8};
		push(vb + 20'h00020, 4'h4, 1'b0, 2'h2);
		push(vb + 20'h00028, 4'h6, 1'b0, 2'h2);
		push(vb + 20'h00030, 4'h8, 1'b0, 2'h1);
		tick(1);
		hw_event_in = 15'h0000;
		tick(3);
		hold = 1'b0;
		wait_done();
		irq_global_off_instr_in = 1'b1;
		tick(1);
		irq_global_off_instr_in = 1'b0;
		s0 = status_out;
		push(vb + 20'h00004, 4'hD, 1'b1, 2'h0);
		trap_pin_in = 1'b1;
		tick(3);
		trap_pin_in = 1'b0;
		wait_done();
		check("status", status_out, s0);
		for (int i = 0; i < 4; i++) begin
			r = $urandom;
			idx = (i == 0) ? 6'h3F : r[5:0];
			sw_index_in = idx;
			push(vb + 20'h00060 + {12'h000, idx, 2'h0}, 4'hC, 1'b0, 2'h0);
			sw_call_in = 1'b1;
			tick(1);
			sw_call_in = 1'b0;
			wait_done();
		end
		hold = 1'b1;
		status_we_in = 1'b1;
		status_wdata_in = 20'h0FFFE;
		prio_b_we_in = 1'b1;
		prio_wdata_in = 20'h300C0;
		irq_global_on_instr_in = 1'b1;
		tick(1);
		status_we_in = 1'b0;
		prio_b_we_in = 1'b0;
		irq_global_on_instr_in = 1'b0;
		hw_event_in = 15'h4200;
		push(vb + 20'h00038, 4'hA, 1'b0, 2'h3);
		push(vb + 20'h0004C, 4'hF, 1'b0, 2'h3);
		tick(1);
		hw_event_in = 15'h0000;
		tick(2);
		check("prio b", int_priority_ctrl_b_out, 20'h300C0);
		hold = 1'b0;
		wait_done();
		pin_mux_select_field_in = 4'h5;
		general_io_bit_in = r[9:6];
		tick(4);
		check("io pins", 20'(service_code_pins_out), 20'(r[9:6]));
		pin_mux_select_field_in = 4'h0;
		tick(3);
		check("idle code", 20'(service_code_pins_out), 20'h0000F);
		check("takes left", 20'(q.size()), 20'h00000);
		finish_test();
	end
endmodule // itc_core_tb_top
bind itc_core itc_core_chk chk_u (.*);
